// ===== logic/blasp_pkg.sv
// Purpose: Constants for the byte-lane asynchronous static memory controller
// Assumes: 250 MHz system clock, 4 ns period
// Notes:   Times in ns; cycle counts derived from them and the clock period
package blasp_pkg;
  localparam int ADDR_WIDTH      = 19;
  localparam int DATA_WIDTH      = 16;
  localparam int LANE_WIDTH      = 8;
  localparam int CLK_PERIOD_NS   = 4;
  // Read cycle and access time
  localparam int READ_CYCLE_NS   = 55;
  localparam int READ_ACCESS_NS  = 55;
  // Write strobe, lane enable and address setup to write end
  localparam int WRITE_PULSE_NS  = 35;
  localparam int DATA_SETUP_NS   = 25;
  // Write recovery between write end and the next cycle (covers total write cycle time)
  localparam int WRITE_CYCLE_NS  = 45;
  // Least times round up to whole cycles
  localparam int READ_CYCLES   = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYCLES = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYCLES  = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WCYCLE_CYCLES = (WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COUNT_WIDTH   = 5;
  localparam logic [COUNT_WIDTH-1:0] READ_COUNT   = COUNT_WIDTH'(READ_CYCLES);
  localparam logic [COUNT_WIDTH-1:0] PULSE_COUNT  = COUNT_WIDTH'(PULSE_CYCLES);
  localparam logic [COUNT_WIDTH-1:0] RECOVER_COUNT =
    COUNT_WIDTH'(WCYCLE_CYCLES - PULSE_CYCLES + 1);
  // Controller states
  typedef enum logic [2:0] {
    BLASP_IDLE    = 3'b000,
    BLASP_READ    = 3'b001,
    BLASP_WSETUP  = 3'b010,
    BLASP_WPULSE  = 3'b011,
    BLASP_WEND    = 3'b100
  } blasp_state_type;
endpackage

// ===== logic/blasp_counter.sv
// Purpose: Down counter that times one memory cycle phase
// Assumes: load and count are never asserted together with conflicting intent
// Notes:   done is high while the count is zero
`timescale 1ns/10ps
module blasp_counter
  import blasp_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   load,
  input  wire logic [COUNT_WIDTH-1:0] loadValue,
  output logic                        done
);
  logic [COUNT_WIDTH-1:0] count_reg;
  logic [COUNT_WIDTH-1:0] count_next;

  // Load takes priority over counting down
  always_comb
  begin
    count_next = count_reg;
    if (load)
      count_next = loadValue;
    else if (count_reg != '0)
      count_next = count_reg - COUNT_WIDTH'(1);
  end

  // Register
  always_ff @(posedge clk)
  begin
    if (reset)
      count_reg <= '0;
    else
      count_reg <= count_next;
  end

  assign done = (count_reg == '0);
endmodule // blasp_counter

// ===== logic/blasp_controller.sv
// Purpose: Host-side controller driving a 512K x 16 asynchronous static memory
// Assumes: Memory pins sampled synchronously; one request at a time
// Notes:   Read data is captured at the end of the read cycle
//
// Behaviour
// - Write: selects active, strobe low, lanes chosen
// - Read: selects active, drive-enable low, strobe high
// - Read cycle lasts at least 55 ns
// - Write address stable 35 ns before end
// - Address stable before write starts
// - Address held until write ends
// - Write data set up 25 ns, held
// - Lane enables low 35 ns before end
// - Write only while all enables overlap
`timescale 1ns/10ps
module blasp_controller
  import blasp_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  reqValid,
  input  wire logic                  reqWrite,
  input  wire logic [ADDR_WIDTH-1:0] reqAddr,
  input  wire logic [DATA_WIDTH-1:0] reqWriteData,
  input  wire logic [1:0]            reqLanes,
  output logic                       reqReady,
  output logic                       readValid,
  output logic [DATA_WIDTH-1:0]      readData,
  output logic [ADDR_WIDTH-1:0]      memAddr,
  output logic                       primary_select_n,
  output logic                       secondary_select,
  output logic                       output_drive_enable_n,
  output logic                       store_strobe_n,
  output logic                       upper_lane_enable_n,
  output logic                       lower_lane_enable_n,
  input  wire logic [DATA_WIDTH-1:0] memDataIn,
  output logic [DATA_WIDTH-1:0]      memDataOut,
  output logic                       memDataOe_n
);
  blasp_state_type        state_reg, state_next;
  logic [ADDR_WIDTH-1:0]  addr_reg, addr_next;
  logic [DATA_WIDTH-1:0]  wdata_reg, wdata_next;
  logic [DATA_WIDTH-1:0]  rdata_reg, rdata_next;
  logic                   rvalid_reg, rvalid_next;
  logic                   ready_reg, ready_next;
  logic                   sel_reg, sel_next;
  logic                   oe_n_reg, oe_n_next;
  logic                   we_n_reg, we_n_next;
  logic                   ub_n_reg, ub_n_next;
  logic                   lb_n_reg, lb_n_next;
  logic                   doe_n_reg, doe_n_next;
  logic                   ctrLoad;
  logic [COUNT_WIDTH-1:0] ctrValue;
  logic                   ctrDone;

  // Phase timer for read, write pulse and write recovery
  blasp_counter u_timer (
    .clk       (clk),
    .reset     (reset),
    .load      (ctrLoad),
    .loadValue (ctrValue),
    .done      (ctrDone)
  );

  // Sequencer: every pin is registered so edges land on clock boundaries
  always_comb
  begin
    state_next  = state_reg;
    addr_next   = addr_reg;
    wdata_next  = wdata_reg;
    rdata_next  = rdata_reg;
    rvalid_next = 1'b0;
    ready_next  = ready_reg;
    sel_next    = sel_reg;
    oe_n_next   = oe_n_reg;
    we_n_next   = we_n_reg;
    ub_n_next   = ub_n_reg;
    lb_n_next   = lb_n_reg;
    doe_n_next  = doe_n_reg;
    ctrLoad     = 1'b0;
    ctrValue    = READ_COUNT;
    case (state_reg)
      BLASP_IDLE:
      begin
        if (reqValid && ready_reg && reqLanes != 2'b00)
        begin
          ready_next = 1'b0;
          addr_next  = reqAddr;
          sel_next   = 1'b1;
          ub_n_next  = ~reqLanes[1];
          lb_n_next  = ~reqLanes[0];
          if (reqWrite)
          begin
            // Address and selects settle one cycle before the strobe
            wdata_next = reqWriteData;
            state_next = BLASP_WSETUP;
          end
          else
          begin
            oe_n_next  = 1'b0;
            ctrLoad    = 1'b1;
            ctrValue   = READ_COUNT;
            state_next = BLASP_READ;
          end
        end
      end
      BLASP_READ:
      begin
        // Timer covers address, enable and lane access times at once
        if (ctrDone)
        begin
          rdata_next  = memDataIn;
          rvalid_next = 1'b1;
          sel_next    = 1'b0;
          oe_n_next   = 1'b1;
          ub_n_next   = 1'b1;
          lb_n_next   = 1'b1;
          ready_next  = 1'b1;
          state_next  = BLASP_IDLE;
        end
      end
      BLASP_WSETUP:
      begin
        we_n_next  = 1'b0;
        doe_n_next = 1'b0;
        ctrLoad    = 1'b1;
        ctrValue   = PULSE_COUNT;
        state_next = BLASP_WPULSE;
      end
      BLASP_WPULSE:
      begin
        // Strobe rises first and ends the write; the rest follow a cycle later
        if (ctrDone)
        begin
          we_n_next  = 1'b1;
          ctrLoad    = 1'b1;
          ctrValue   = RECOVER_COUNT;
          state_next = BLASP_WEND;
        end
      end
      BLASP_WEND:
      begin
        // Data and address held past the ending edge before release
        sel_next   = 1'b0;
        ub_n_next  = 1'b1;
        lb_n_next  = 1'b1;
        doe_n_next = 1'b1;
        if (ctrDone)
        begin
          ready_next = 1'b1;
          state_next = BLASP_IDLE;
        end
      end
      default:
        state_next = BLASP_IDLE;
    endcase
  end

  // Registers; reset leaves memory deselected and data bus released
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg  <= BLASP_IDLE;
      addr_reg   <= '0;
      wdata_reg  <= '0;
      rdata_reg  <= '0;
      rvalid_reg <= 1'b0;
      ready_reg  <= 1'b1;
      sel_reg    <= 1'b0;
      oe_n_reg   <= 1'b1;
      we_n_reg   <= 1'b1;
      ub_n_reg   <= 1'b1;
      lb_n_reg   <= 1'b1;
      doe_n_reg  <= 1'b1;
    end
    else
    begin
      state_reg  <= state_next;
      addr_reg   <= addr_next;
      wdata_reg  <= wdata_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
      ready_reg  <= ready_next;
      sel_reg    <= sel_next;
      oe_n_reg   <= oe_n_next;
      we_n_reg   <= we_n_next;
      ub_n_reg   <= ub_n_next;
      lb_n_reg   <= lb_n_next;
      doe_n_reg  <= doe_n_next;
    end
  end

  // Outputs straight from flip-flops
  assign reqReady              = ready_reg;
  assign readValid             = rvalid_reg;
  assign readData              = rdata_reg;
  assign memAddr               = addr_reg;
  assign primary_select_n      = ~sel_reg;
  assign secondary_select      = sel_reg;
  assign output_drive_enable_n = oe_n_reg;
  assign store_strobe_n        = we_n_reg;
  assign upper_lane_enable_n   = ub_n_reg;
  assign lower_lane_enable_n   = lb_n_reg;
  assign memDataOut            = wdata_reg;
  assign memDataOe_n           = doe_n_reg;

  // Helper: cycles the strobe and the drive enable have been low; saturates at all ones
  logic [COUNT_WIDTH-1:0] strobeLow_reg, strobeLow_next;
  logic [COUNT_WIDTH-1:0] readLow_reg, readLow_next;
  always_comb
  begin
    strobeLow_next = '0;
    readLow_next   = '0;
    if (!we_n_reg)
      strobeLow_next = strobeLow_reg + COUNT_WIDTH'(strobeLow_reg != '1);
    if (!oe_n_reg)
      readLow_next = readLow_reg + COUNT_WIDTH'(readLow_reg != '1);
  end

  // Counters kept apart from the sequencer so the checks never feed the pins
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      strobeLow_reg <= '0;
      readLow_reg   <= '0;
    end
    else
    begin
      strobeLow_reg <= strobeLow_next;
      readLow_reg   <= readLow_next;
    end
  end

  sequence readStart;
    $fell(output_drive_enable_n);
  endsequence
  sequence readEnd;
    $rose(output_drive_enable_n);
  endsequence

  strobe_width_a: assert property (@(posedge clk) disable iff (reset)
    $rose(store_strobe_n) |-> $past(strobeLow_reg) >= COUNT_WIDTH'(PULSE_CYCLES))
    else $error("write strobe shorter than minimum");
  read_length_a: assert property (@(posedge clk) disable iff (reset)
    readEnd |-> $past(readLow_reg) >= COUNT_WIDTH'(READ_CYCLES))
    else $error("read cycle too short");
  read_lanes_a: assert property (@(posedge clk) disable iff (reset)
    readStart |-> !(upper_lane_enable_n && lower_lane_enable_n) && readLow_reg == '0)
    else $error("read started without a lane");
  data_contention_a: assert property (@(posedge clk) disable iff (reset)
    !memDataOe_n |-> output_drive_enable_n && !store_strobe_n || $past(!store_strobe_n))
    else $error("data driven outside write");
  read_no_strobe_a: assert property (@(posedge clk) disable iff (reset)
    !output_drive_enable_n |-> store_strobe_n && !primary_select_n && secondary_select)
    else $error("read conditions broken");
  write_select_a: assert property (@(posedge clk) disable iff (reset)
    !store_strobe_n |-> !primary_select_n && secondary_select
      && !(upper_lane_enable_n && lower_lane_enable_n))
    else $error("write without selects");
  addr_stable_a: assert property (@(posedge clk) disable iff (reset)
    !store_strobe_n || $rose(store_strobe_n) |-> $stable(memAddr))
    else $error("address moved during write");
  addr_setup_a: assert property (@(posedge clk) disable iff (reset)
    $fell(store_strobe_n) |-> $stable(memAddr) && !primary_select_n)
    else $error("address not set before write");
  data_hold_a: assert property (@(posedge clk) disable iff (reset)
    $rose(store_strobe_n) |-> $stable(memDataOut) && !memDataOe_n)
    else $error("write data not held");
  idle_standby_a: assert property (@(posedge clk) disable iff (reset)
    readEnd |-> primary_select_n && !secondary_select && reqReady)
    else $error("not deselected after read");
  read_capture_a: assert property (@(posedge clk) disable iff (reset)
    readEnd |-> readValid)
    else $error("read data not returned");
endmodule // blasp_controller

// ===== sim/blasp_sram_model.sv
// Purpose: Behavioural 512K x 16 static memory on the controller's pins
// Assumes: Pins move on clk edges; read data shows ACCESS_NS after a change
// Notes:   Floating lines toggle each cycle so a stale value never passes
`timescale 1ns/10ps
module blasp_sram_model
  import blasp_pkg::*;
#(
  parameter int ACCESS_NS = READ_ACCESS_NS,
  parameter int HOLD_NS   = 10
)
(
  input  wire logic                  clk,
  input  wire logic [ADDR_WIDTH-1:0] memAddr,
  input  wire logic                  primary_select_n,
  input  wire logic                  secondary_select,
  input  wire logic                  output_drive_enable_n,
  input  wire logic                  store_strobe_n,
  input  wire logic                  upper_lane_enable_n,
  input  wire logic                  lower_lane_enable_n,
  input  wire logic [DATA_WIDTH-1:0] memDataOut,
  input  wire logic                  memDataOe_n,
  output logic [DATA_WIDTH-1:0]      memDataIn,
  output int                         errCount
);
  logic [DATA_WIDTH-1:0] mem [0:(1<<ADDR_WIDTH)-1];
  logic [DATA_WIDTH-1:0] last = 16'h0000;
  logic [ADDR_WIDTH-1:0] wrAddr, heldAddr, shownAddr;
  logic [DATA_WIDTH-1:0] wrData, rdWord;
  logic                  sel, rdOn, wrOn;
  logic                  dataOk = 1'b0;
  logic                  holdOk = 1'b0;
  int                    gen, rdLen, wrLen;
  // Deselect is either select inactive or no lane enabled
  assign sel = !primary_select_n && secondary_select &&
               !(upper_lane_enable_n && lower_lane_enable_n);
  assign rdOn = sel && !output_drive_enable_n && store_strobe_n;
  assign wrOn = sel && !store_strobe_n;
  // Access timer restarts on every change of what is read; the old word lingers briefly
  always @(memAddr, rdOn, upper_lane_enable_n, lower_lane_enable_n)
  begin
    gen++;
    if (!rdOn)
      holdOk = 1'b0;
    else if (dataOk)
    begin
      holdOk   = 1'b1;
      heldAddr = shownAddr;
    end
    dataOk = 1'b0;
    fork
      automatic int g = gen;
      begin
        #(HOLD_NS) if (g == gen) holdOk = 1'b0;
      end
      begin
        #(ACCESS_NS) if (g == gen && rdOn)
        begin
          shownAddr = memAddr;
          dataOk    = 1'b1;
        end
      end
    join_none
  end
  // Word on the pins: new once valid, otherwise the one still held
  assign rdWord = dataOk ? mem[memAddr] : mem[heldAddr];
  // Only enabled lanes are driven; outputs float while writing
  always_comb
  begin
    memDataIn = ~last;
    if (!memDataOe_n)
      memDataIn = memDataOut;
    else if (rdOn && (dataOk || holdOk))
    begin
      if (!upper_lane_enable_n) memDataIn[15:8] = rdWord[15:8];
      if (!lower_lane_enable_n) memDataIn[7:0] = rdWord[7:0];
    end
  end
  // First enable to drop ends the write; lanes store independently
  always @(negedge wrOn)
  begin
    if (!lower_lane_enable_n) mem[memAddr][7:0] = memDataIn[7:0];
    if (!upper_lane_enable_n) mem[memAddr][15:8] = memDataIn[15:8];
  end
  // Controller timing watched in whole cycles; faults only counted
  initial errCount = 0;
  always @(posedge clk)
  begin
    last <= memDataIn;
    rdLen <= rdOn ? rdLen + 1 : 0;
    wrLen <= wrOn ? wrLen + 1 : 0;
    if (wrOn && wrLen == 0) wrAddr <= memAddr;
    if (wrOn && wrLen == 0) wrData <= memDataOut;
    if (wrOn && (memDataOe_n || (wrLen > 0 && memDataOut !== wrData))) errCount <= errCount + 1;
    if (!memDataOe_n && rdOn) errCount <= errCount + 1;
    if (wrOn && wrLen > 0 && memAddr !== wrAddr) errCount <= errCount + 1;
    if (!rdOn && rdLen > 0 && rdLen < READ_CYCLES) errCount <= errCount + 1;
    if (!wrOn && wrLen > 0 && wrLen < PULSE_CYCLES) errCount <= errCount + 1;
  end
endmodule // blasp_sram_model

// ===== sim/blasp_tb.sv
// Purpose: Self-checking bench for the static memory controller
// Assumes: Memory model answers 55 ns after each change, its slowest legal access
// Notes:   Inputs move 1 ns after the rising edge
`timescale 1ns/10ps
module tb;
  import blasp_pkg::*;
  localparam int D = 1;
  logic                  clk, reset, reqValid, reqWrite, reqReady, readValid, memDataOe_n;
  logic                  primary_select_n, secondary_select, output_drive_enable_n;
  logic                  store_strobe_n, upper_lane_enable_n, lower_lane_enable_n;
  logic [1:0]            reqLanes;
  logic [ADDR_WIDTH-1:0] reqAddr, memAddr;
  logic [DATA_WIDTH-1:0] reqWriteData, readData, memDataIn, memDataOut;
  int                    errCount, compares, miscompares;
  blasp_controller blasp_controller_inst (.clk(clk), .reset(reset), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWriteData(reqWriteData),
    .reqLanes(reqLanes), .reqReady(reqReady), .readValid(readValid), .readData(readData),
    .memAddr(memAddr), .primary_select_n(primary_select_n),
    .secondary_select(secondary_select), .output_drive_enable_n(output_drive_enable_n),
    .store_strobe_n(store_strobe_n), .upper_lane_enable_n(upper_lane_enable_n),
    .lower_lane_enable_n(lower_lane_enable_n), .memDataIn(memDataIn),
    .memDataOut(memDataOut), .memDataOe_n(memDataOe_n));
  blasp_sram_model blasp_sram_model_inst (.clk(clk), .memAddr(memAddr),
    .primary_select_n(primary_select_n), .secondary_select(secondary_select),
    .output_drive_enable_n(output_drive_enable_n), .store_strobe_n(store_strobe_n),
    .upper_lane_enable_n(upper_lane_enable_n), .lower_lane_enable_n(lower_lane_enable_n),
    .memDataOut(memDataOut), .memDataOe_n(memDataOe_n), .memDataIn(memDataIn),
    .errCount(errCount));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Present one request while ready; count cycles to its answer
  task automatic request(input logic wr, input logic [ADDR_WIDTH-1:0] a,
                         input logic [DATA_WIDTH-1:0] d, input logic [1:0] ln, output int lat);
    lat = 0;
    {reqValid, reqWrite, reqAddr, reqWriteData, reqLanes} = {1'b1, wr, a, d, ln};
    @(posedge clk);
    #D reqValid = 1'b0;
    while ((lat == 0 || (wr ? reqReady !== 1'b1 : readValid !== 1'b1)) && lat < 40)
    begin
      @(posedge clk);
      #D lat++;
    end
  endtask
  task automatic test_reset();
    chk("reqReady", 32'h1, reqReady);
    chk("selects", 32'h2, {primary_select_n, secondary_select});
    chk("enables", 32'hF, {output_drive_enable_n, store_strobe_n, upper_lane_enable_n,
        lower_lane_enable_n});
    chk("memDataOe_n", 32'h1, memDataOe_n);
    chk("memAddr", 32'h0, memAddr);
    $display("test_reset done");
  endtask
  // Byte lanes merge in one word; reads follow writes back to back
  task automatic test_lanes();
    int lat;
    request(1'b1, 19'h7FFFF, 16'h1234, 2'b11, lat);
    chk("write latency", 32'h10, lat);
    request(1'b1, 19'h7FFFF, 16'hAB99, 2'b10, lat);
    request(1'b1, 19'h7FFFF, 16'h77CD, 2'b01, lat);
    request(1'b0, 19'h7FFFF, 16'h0000, 2'b11, lat);
    chk("read latency", 32'hF, lat);
    chk("word", 32'hABCD, readData);
    request(1'b0, 19'h7FFFF, 16'h0000, 2'b10, lat);
    chk("upper", 32'hAB, readData[15:8]);
    request(1'b0, 19'h7FFFF, 16'h0000, 2'b01, lat);
    chk("lower", 32'hCD, readData[7:0]);
    $display("test_lanes done");
  endtask
  // Top address bit must select a different word
  task automatic test_addr();
    int lat;
    request(1'b1, 19'h00000, 16'h5A5A, 2'b11, lat);
    request(1'b1, 19'h40000, 16'hC3C3, 2'b11, lat);
    request(1'b0, 19'h00000, 16'h0000, 2'b11, lat);
    chk("word zero", 32'h5A5A, readData);
    request(1'b0, 19'h40000, 16'h0000, 2'b11, lat);
    chk("word top", 32'hC3C3, readData);
    $display("test_addr done");
  endtask
  // No lane asked: memory stays deselected in standby
  task automatic test_ignored();
    {reqValid, reqWrite, reqLanes} = {1'b1, 1'b1, 2'b00};
    repeat (8)
    begin
      @(posedge clk);
      #D chk("idle select", 32'h1, primary_select_n);
      chk("idle ready", 32'h1, reqReady);
    end
    reqValid = 1'b0;
    $display("test_ignored done");
  endtask
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Clock at 250 MHz
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Hang guard, far beyond the roughly 190 cycles needed
  initial
  begin
    #20000;
    miscompares++;
    conclude();
  end
  // Main sequence
  initial
  begin
    {reqValid, reqWrite, reqAddr, reqWriteData, reqLanes} = 0;
    reset = 1'b1;
    repeat (16) @(posedge clk);
    #D reset = 1'b0;
    test_reset();
    test_lanes();
    test_addr();
    test_ignored();
    chk("model faults", 32'h0, errCount);
    conclude();
  end
endmodule // tb
